/* bench/ehm_history_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; $display("[FAIL] %s exp %h seen %h", n, e, g); end end
module ehm_history_tb;
  logic I_MCLK = 1'h0, I_RSTN = 1'h0, I_ERR_DET = 1'h0, I_STAGE_ENABLED = 1'h0, I_FAULT_RESET = 1'h0;
  logic rd, wr, ack, err, ok, msg, sdis, qs, stand = 1'h1;
  logic [15:0] addr, code;
  logic [31:0] wd, rdat, q, secs = 32'h0, pwr = 32'h0;
  logic [191:0] r;
  logic [3:0] cnt;
  logic [3:0] nib[11] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hA, 4'hB, 4'h9};
  ehm_pkg::ehm_snap_t snap = '0;
  ehm_pkg::ehm_cat_t cat;
  ehm_pkg::ehm_entry_t hist[$];
  int failures = 0, num_checks = 0, seed = 33105, n;
  int cyc = 0;
  always #10 I_MCLK = ~I_MCLK;
  // edges since reset release, stage is enabled at release
  always @(posedge I_MCLK) if (I_RSTN) cyc++;
  ehm_master i_ehm_master (.i_clk(I_MCLK), .o_rd(rd), .o_wr(wr), .o_addr(addr), .o_wdata(wd),
    .i_ack(ack), .i_err(err), .i_rdata(rdat));
  ehm_history #(.SEC_CYCLES(10)) i_ehm_history (.I_MCLK(I_MCLK), .I_RSTN(I_RSTN), .I_PAR_RD(rd),
    .I_PAR_WR(wr), .I_PAR_ADDR(addr), .I_PAR_WDATA(wd), .O_PAR_ACK(ack), .O_PAR_ERR(err),
    .O_PAR_RDATA(rdat), .I_ERR_DET(I_ERR_DET), .I_ERR_SNAP(snap), .I_OP_SECONDS(secs),
    .I_PWRON_CNT_NV(pwr), .I_STAGE_ENABLED(I_STAGE_ENABLED), .I_STANDSTILL(stand),
    .I_FAULT_RESET(I_FAULT_RESET), .O_ERR_MSG_VALID(msg), .O_ERR_MSG_CODE(code),
    .O_ERR_CATEGORY(cat), .O_HIST_COUNT(cnt), .O_QUICK_STOP(qs), .O_STAGE_DISABLE(sdis),
    .O_TRANS_QUICK_STOP(), .O_TRANS_FAULT_REACTION(), .O_TRANS_FAULT_STATE(), .O_WARNING(),
    .O_FAULT());
  function automatic ehm_pkg::ehm_cat_t cat_of(input logic [3:0] t);
    if (t == 4'h0 || t == 4'h9 || t > 4'hB) return ehm_pkg::CAT_NONE;
    return ehm_pkg::ehm_cat_t'(t);
  endfunction
  function automatic logic [31:0] field(input ehm_pkg::ehm_entry_t e, input int k);
    logic [31:0] f[11];
    f = '{{16'h0, e.snap.code}, {29'h0, e.snap.cls}, e.det_time, {16'h0, e.snap.qual},
          {16'h0, e.en_count}, {16'h0, e.en_time}, {16'h0, e.snap.dc_bus}, e.snap.velocity,
          {16'h0, e.snap.current},
          {16'h0, e.snap.temp_ps}, {16'h0, e.snap.temp_dev}};
    return f[k];
  endfunction
  task automatic log_err(input logic [2:0] c, input logic [3:0] t);
    @(negedge I_MCLK);
    r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    {snap, secs} = r[162:0];
    snap.code[15:12] = t;
    snap.cls = c;
    I_ERR_DET = 1'h1;
    // one second per ten edges, tick lands one edge late
    hist.push_back({snap, (secs > ehm_pkg::TIME_MAX) ? ehm_pkg::TIME_MAX : secs, 16'h1, 16'((cyc - 1) / 10)});
    if (hist.size() > 10) void'(hist.pop_front());
    @(negedge I_MCLK);
    I_ERR_DET = 1'h0;
    `CHK("msg", {1'h1, snap.code, cat_of(t)}, {msg, code, cat})
    `CHK("count", 4'(hist.size()), cnt)
  endtask
  task automatic read_all;
    logic [15:0] a[11];
    a = '{ehm_pkg::A_CODE, ehm_pkg::A_CLASS, ehm_pkg::A_TIME, ehm_pkg::A_QUAL, ehm_pkg::A_EN_CNT,
          ehm_pkg::A_EN_TIME, ehm_pkg::A_DCBUS, ehm_pkg::A_VEL, ehm_pkg::A_CURR, ehm_pkg::A_TEMP_PS,
          ehm_pkg::A_TEMP_DEV};
    i_ehm_master.xfer(1'h1, ehm_pkg::A_PTR_RST, 32'h1, ok, q);
    foreach (hist[i]) for (int k = 0; k < 11; k++) begin
      i_ehm_master.xfer(1'h0, a[k], 32'h0, ok, q);
      `CHK("field", {1'h1, field(hist[i], k)}, {ok, q})
    end
    i_ehm_master.xfer(1'h0, ehm_pkg::A_CODE, 32'h0, ok, q);
    `CHK("end code", 32'h0, q)
  endtask
  task automatic fault_reset;
    @(negedge I_MCLK) I_FAULT_RESET = 1'h1;
    @(negedge I_MCLK) I_FAULT_RESET = 1'h0;
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    pwr = $random(seed);
    repeat (4) @(negedge I_MCLK);
    I_RSTN = 1'h1;
    I_STAGE_ENABLED = 1'h1;
    i_ehm_master.xfer(1'h0, ehm_pkg::A_POWER_ON, 32'h0, ok, q);
    `CHK("power on", pwr, q)
    i_ehm_master.xfer(1'h1, ehm_pkg::A_TIME, 32'h1, ok, q);
    `CHK("ro write", 1'h0, ok)
    for (int i = 0; i < 12; i++) log_err(3'h0, nib[i % 11]);
    read_all();
    i_ehm_master.xfer(1'h1, ehm_pkg::A_CLEAR, 32'h1, ok, q);
    hist.delete();
    `CHK("cleared", 4'h0, cnt)
    n = 0;
    do begin
      i_ehm_master.xfer(1'h0, ehm_pkg::A_CLEAR, 32'h0, ok, q);
      n++;
    end while (q !== 32'h0 && n < 20);
    `CHK("clear done", 2'h3, {n > 1, q === 32'h0})
    read_all();
    log_err(3'h3, 4'h3);
    `CHK("cls3 off", 1'h1, sdis)
    fault_reset();
    `CHK("cls3 reset", 1'h0, sdis)
    log_err(3'h1, 4'hA);
    `CHK("cls1 qs", 2'h2, {qs, sdis})
    fault_reset();
    stand = 1'h0;
    log_err(3'h2, 4'h2);
    `CHK("cls2 qs", 2'h2, {qs, sdis})
    @(negedge I_MCLK) stand = 1'h1;
    @(negedge I_MCLK);
    `CHK("cls2 off", 2'h1, {qs, sdis})
    fault_reset();
    log_err(3'h4, 4'h4);
    fault_reset();
    `CHK("cls4 held", 1'h1, sdis)
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge I_MCLK);
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire

/* bench/ehm_master.sv */
`timescale 1ns/10ps
`default_nettype none
module ehm_master (
  // clock
  input wire logic i_clk,
  // parameter port
  output logic o_rd,
  output logic o_wr,
  output logic [15:0] o_addr,
  output logic [31:0] o_wdata,
  input wire logic i_ack,
  input wire logic i_err,
  input wire logic [31:0] i_rdata
);
  initial {o_rd, o_wr, o_addr, o_wdata} = '0;
  // one pulsed request, answer taken a cycle later
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic ok, output logic [31:0] q);
    @(negedge i_clk);
    {o_rd, o_wr, o_addr, o_wdata} = {~w, w, a, d};
    @(negedge i_clk);
    // released lines show the inverse
    {o_rd, o_wr, o_addr, o_wdata} = {2'h0, ~a, ~d};
    ok = i_ack & ~i_err;
    q = i_rdata;
  endtask
endmodule
`default_nettype wire

/* src/ehm_history.sv */
`timescale 1ns/10ps
`default_nettype none
module ehm_history #(
  parameter int unsigned SEC_CYCLES = ehm_pkg::SEC_CYC
) (
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_RSTN,
  // parameter access
  input wire logic I_PAR_RD,
  input wire logic I_PAR_WR,
  input wire logic [15:0] I_PAR_ADDR,
  input wire logic [31:0] I_PAR_WDATA,
  output logic O_PAR_ACK,
  output logic O_PAR_ERR,
  output logic [31:0] O_PAR_RDATA,
  // error detection and snapshot sources
  input wire logic I_ERR_DET,
  input wire ehm_pkg::ehm_snap_t I_ERR_SNAP,
  input wire logic [31:0] I_OP_SECONDS,
  input wire logic [31:0] I_PWRON_CNT_NV,
  // drive state
  input wire logic I_STAGE_ENABLED,
  input wire logic I_STANDSTILL,
  input wire logic I_FAULT_RESET,
  // error message
  output logic O_ERR_MSG_VALID,
  output logic [15:0] O_ERR_MSG_CODE,
  output ehm_pkg::ehm_cat_t O_ERR_CATEGORY,
  output logic [3:0] O_HIST_COUNT,
  // error reaction
  output logic O_QUICK_STOP,
  output logic O_STAGE_DISABLE,
  output logic O_TRANS_QUICK_STOP,
  output logic O_TRANS_FAULT_REACTION,
  output logic O_TRANS_FAULT_STATE,
  output logic O_WARNING,
  output logic O_FAULT
);
  function automatic logic [3:0] wrap_add(input logic [3:0] base, input logic [3:0] off);
    logic [4:0] sum;
    sum = {1'b0, base} + {1'b0, off};
    if (sum >= {1'b0, ehm_pkg::HIST_DEPTH}) begin
      sum = sum - {1'b0, ehm_pkg::HIST_DEPTH};
    end
    return sum[3:0];
  endfunction

  function automatic logic [15:0] sat_inc16(input logic [15:0] v);
    return (v == ehm_pkg::SAT16) ? v : v + 16'h0001;
  endfunction

  function automatic ehm_pkg::ehm_cat_t cat_of(input logic [15:0] code);
    ehm_pkg::ehm_cat_t c;
    c = ehm_pkg::CAT_NONE;
    if (code[15:12] != 4'h0 && code[15:12] != 4'h9 && code[15:12] <= 4'hB) begin
      c = ehm_pkg::ehm_cat_t'(code[15:12]);
    end
    return c;
  endfunction

  logic [31:0] sec_cnt_reg;
  logic sec_tick_reg;
  logic stage_prev_reg;
  logic [15:0] en_count_reg;
  logic [15:0] en_time_reg;
  logic cap_done_reg;
  logic [31:0] power_on_reg;
  logic [3:0] head_reg;
  logic [3:0] count_reg;
  logic [3:0] rd_ptr_reg;
  logic [3:0] clr_busy_reg;
  ehm_pkg::ehm_entry_t hold_reg;
  logic ack_reg;
  logic err_reg;
  logic [31:0] rdata_reg;
  logic msg_valid_reg;
  logic [15:0] msg_code_reg;
  ehm_pkg::ehm_cat_t category_reg;

  logic log_evt;
  logic stage_rise;
  logic full;
  logic entry_avail;
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic [15:0] log_code;
  logic [31:0] det_time;
  ehm_pkg::ehm_entry_t wr_entry;
  ehm_pkg::ehm_entry_t rd_entry;
  logic dec_hit;
  logic [31:0] dec_rdata;
  logic clr_cmd;
  logic ptr_cmd;
  logic code_rd;

  assign log_evt = I_ERR_DET;
  assign log_code = I_ERR_SNAP.code;
  assign stage_rise = I_STAGE_ENABLED && !stage_prev_reg;
  assign full = count_reg == ehm_pkg::HIST_DEPTH;
  assign entry_avail = rd_ptr_reg < count_reg;
  assign rd_idx = wrap_add(head_reg, rd_ptr_reg);
  assign det_time = (I_OP_SECONDS > ehm_pkg::TIME_MAX) ? ehm_pkg::TIME_MAX : I_OP_SECONDS;

  // full history reuses the oldest slot, clear restarts at slot 0
  always_comb begin
    if (clr_cmd) begin
      wr_idx = 4'h0;
    end else if (full) begin
      wr_idx = head_reg;
    end else begin
      wr_idx = wrap_add(head_reg, count_reg);
    end
  end

  always_comb begin
    wr_entry.snap = I_ERR_SNAP;
    wr_entry.det_time = det_time;
    wr_entry.en_count = en_count_reg;
    wr_entry.en_time = en_time_reg;
  end

  ehm_store u_store (
    .i_clk(I_MCLK),
    .i_wr(log_evt),
    .i_wr_idx(wr_idx),
    .i_wr_data(wr_entry),
    .i_rd_idx(rd_idx),
    .o_rd_data(rd_entry)
  );

  ehm_reaction u_reaction (
    .i_clk(I_MCLK),
    .i_rst_n(I_RSTN),
    .i_log(log_evt),
    .i_cls(I_ERR_SNAP.cls),
    .i_fault_reset(I_FAULT_RESET),
    .i_standstill(I_STANDSTILL),
    .o_quick_stop(O_QUICK_STOP),
    .o_stage_off(O_STAGE_DISABLE),
    .o_t_qs(O_TRANS_QUICK_STOP),
    .o_t_fr(O_TRANS_FAULT_REACTION),
    .o_t_fs(O_TRANS_FAULT_STATE),
    .o_warning(O_WARNING),
    .o_fault(O_FAULT)
  );

  // one-second tick
  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      sec_cnt_reg <= '0;
      sec_tick_reg <= 1'b0;
    end else if (sec_cnt_reg == 32'(SEC_CYCLES - 1)) begin
      sec_cnt_reg <= '0;
      sec_tick_reg <= 1'b1;
    end else begin
      sec_cnt_reg <= sec_cnt_reg + 32'h00000001;
      sec_tick_reg <= 1'b0;
    end
  end

  // power stage enable count and time since last enable
  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      stage_prev_reg <= 1'b0;
      en_count_reg <= '0;
      en_time_reg <= '0;
    end else begin
      stage_prev_reg <= I_STAGE_ENABLED;
      if (stage_rise) begin
        en_count_reg <= sat_inc16(en_count_reg);
        en_time_reg <= '0;
      end else if (sec_tick_reg) begin
        en_time_reg <= sat_inc16(en_time_reg);
      end
    end
  end

  // power-on count caught in the first cycle after reset release
  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      cap_done_reg <= 1'b0;
      power_on_reg <= '0;
    end else if (!cap_done_reg) begin
      cap_done_reg <= 1'b1;
      power_on_reg <= I_PWRON_CNT_NV;
    end
  end

  // parameter decode; a write takes precedence over a read
  always_comb begin
    dec_hit = 1'b1;
    dec_rdata = '0;
    clr_cmd = 1'b0;
    ptr_cmd = 1'b0;
    code_rd = 1'b0;
    if (I_PAR_WR) begin
      if (I_PAR_ADDR == ehm_pkg::A_CLEAR && I_PAR_WDATA <= ehm_pkg::CMD_MAX) begin
        clr_cmd = I_PAR_WDATA == ehm_pkg::CMD_ON;
      end else if (I_PAR_ADDR == ehm_pkg::A_PTR_RST && I_PAR_WDATA <= ehm_pkg::CMD_MAX) begin
        ptr_cmd = I_PAR_WDATA == ehm_pkg::CMD_ON;
      end else begin
        dec_hit = 1'b0;
      end
    end else if (I_PAR_RD) begin
      if (I_PAR_ADDR == ehm_pkg::A_CODE) begin
        code_rd = 1'b1;
        if (entry_avail) begin
          dec_rdata = {16'h0000, rd_entry.snap.code};
        end
      end else if (I_PAR_ADDR == ehm_pkg::A_CLASS) begin
        dec_rdata = {29'h00000000, hold_reg.snap.cls};
      end else if (I_PAR_ADDR == ehm_pkg::A_POWER_ON) begin
        dec_rdata = power_on_reg;
      end else if (I_PAR_ADDR == ehm_pkg::A_CLEAR) begin
        dec_rdata = {31'h00000000, clr_busy_reg != 4'h0};
      end else if (I_PAR_ADDR == ehm_pkg::A_PTR_RST) begin
        dec_rdata = '0;
      end else if (I_PAR_ADDR == ehm_pkg::A_TIME) begin
        dec_rdata = hold_reg.det_time;
      end else if (I_PAR_ADDR == ehm_pkg::A_QUAL) begin
        dec_rdata = {16'h0000, hold_reg.snap.qual};
      end else if (I_PAR_ADDR == ehm_pkg::A_EN_CNT) begin
        dec_rdata = {16'h0000, hold_reg.en_count};
      end else if (I_PAR_ADDR == ehm_pkg::A_EN_TIME) begin
        dec_rdata = {16'h0000, hold_reg.en_time};
      end else if (I_PAR_ADDR == ehm_pkg::A_DCBUS) begin
        dec_rdata = {16'h0000, hold_reg.snap.dc_bus};
      end else if (I_PAR_ADDR == ehm_pkg::A_VEL) begin
        dec_rdata = hold_reg.snap.velocity;
      end else if (I_PAR_ADDR == ehm_pkg::A_CURR) begin
        dec_rdata = {16'h0000, hold_reg.snap.current};
      end else if (I_PAR_ADDR == ehm_pkg::A_TEMP_PS) begin
        dec_rdata = {16'h0000, hold_reg.snap.temp_ps};
      end else if (I_PAR_ADDR == ehm_pkg::A_TEMP_DEV) begin
        dec_rdata = {16'h0000, hold_reg.snap.temp_dev};
      end else begin
        dec_hit = 1'b0;
      end
    end
  end

  // access answer one cycle after the request
  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg <= I_PAR_RD || I_PAR_WR;
      err_reg <= (I_PAR_RD || I_PAR_WR) && !dec_hit;
      rdata_reg <= dec_rdata;
    end
  end

  // ring occupancy; a logged error in the clear cycle survives
  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      head_reg <= '0;
      count_reg <= '0;
    end else if (clr_cmd) begin
      head_reg <= '0;
      count_reg <= log_evt ? 4'h1 : 4'h0;
    end else if (log_evt) begin
      if (full) begin
        head_reg <= wrap_add(head_reg, 4'h1);
      end else begin
        count_reg <= count_reg + 4'h1;
      end
    end
  end

  // deletion status seen by the master
  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      clr_busy_reg <= '0;
    end else if (clr_cmd) begin
      clr_busy_reg <= ehm_pkg::CLEAR_CYC;
    end else if (clr_busy_reg != 4'h0) begin
      clr_busy_reg <= clr_busy_reg - 4'h1;
    end
  end

  // sequential read pointer and holding buffer
  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      rd_ptr_reg <= '0;
      hold_reg <= '0;
    end else if (clr_cmd || ptr_cmd) begin
      rd_ptr_reg <= '0;
      if (clr_cmd) begin
        hold_reg <= '0;
      end
    end else if (code_rd) begin
      if (entry_avail) begin
        hold_reg <= rd_entry;
        rd_ptr_reg <= rd_ptr_reg + 4'h1;
      end else begin
        hold_reg <= '0;
      end
    end
  end

  // error message
  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      msg_valid_reg <= 1'b0;
      msg_code_reg <= '0;
      category_reg <= ehm_pkg::CAT_NONE;
    end else begin
      msg_valid_reg <= log_evt;
      if (log_evt) begin
        msg_code_reg <= log_code;
        category_reg <= cat_of(log_code);
      end
    end
  end

  assign O_PAR_ACK = ack_reg;
  assign O_PAR_ERR = err_reg;
  assign O_PAR_RDATA = rdata_reg;
  assign O_ERR_MSG_VALID = msg_valid_reg;
  assign O_ERR_MSG_CODE = msg_code_reg;
  assign O_ERR_CATEGORY = category_reg;
  assign O_HIST_COUNT = count_reg;

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RSTN);

  property p_pwron_stable;
    (cap_done_reg && $past(cap_done_reg)) |-> $stable(power_on_reg);
  endproperty
  a_pwron_stable: assert property (p_pwron_stable) else $error("power-on count changed");
  property p_time_limit;
    log_evt |-> wr_entry.det_time <= ehm_pkg::TIME_MAX && wr_entry.det_time <= I_OP_SECONDS;
  endproperty
  a_time_limit: assert property (p_time_limit) else $error("detection time over limit");
  property p_en_time_restart;
    (stage_rise && !sec_tick_reg) |=> en_time_reg == 16'h0000 ##1 en_time_reg <= 16'h0001;
  endproperty
  a_en_time_restart: assert property (p_en_time_restart) else $error("enable time not restarted");
  property p_ptr_reset;
    ptr_cmd |=> rd_ptr_reg == 4'h0 && O_PAR_ACK && !O_PAR_ERR;
  endproperty
  a_ptr_reset: assert property (p_ptr_reset) else $error("read pointer not reset");
  property p_clear_now;
    (clr_cmd && !log_evt) |=> count_reg == 4'h0 && rd_ptr_reg == 4'h0;
  endproperty
  a_clear_now: assert property (p_clear_now) else $error("clear did not empty history");
  property p_clear_done;
    clr_cmd ##1 (!clr_cmd)[*8] |=> ##2 clr_busy_reg == 4'h0 && $past(clr_busy_reg) == 4'h1;
  endproperty
  a_clear_done: assert property (p_clear_done) else $error("clear status wrong length");
  property p_msg_code;
    log_evt |=> O_ERR_MSG_VALID && O_ERR_MSG_CODE == $past(log_code);
  endproperty
  a_msg_code: assert property (p_msg_code) else $error("message code mismatch");
  property p_category;
    O_ERR_MSG_VALID |-> O_ERR_CATEGORY == cat_of(O_ERR_MSG_CODE);
  endproperty
  a_category: assert property (p_category) else $error("category mismatch");
  property p_read_advance;
    (code_rd && entry_avail) |=> rd_ptr_reg == $past(rd_ptr_reg) + 4'h1 && hold_reg == $past(rd_entry);
  endproperty
  a_read_advance: assert property (p_read_advance) else $error("read did not copy and advance");
  property p_depth;
    count_reg <= ehm_pkg::HIST_DEPTH;
  endproperty
  a_depth: assert property (p_depth) else $error("history above ten");
  property p_end_zero;
    (code_rd && !entry_avail) |=> O_PAR_ACK && O_PAR_RDATA == 32'h00000000;
  endproperty
  a_end_zero: assert property (p_end_zero) else $error("end of history not zero");
  property p_full_drop;
    (log_evt && full && !clr_cmd) |=> count_reg == ehm_pkg::HIST_DEPTH && head_reg == wrap_add($past(head_reg), 4'h1);
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("oldest entry not discarded");
  c_full_log: cover property (log_evt && full);
  c_clear_poll: cover property (clr_cmd ##[1:20] (I_PAR_RD && I_PAR_ADDR == ehm_pkg::A_CLEAR && clr_busy_reg == 4'h0));
  c_read_to_end: cover property ((code_rd && entry_avail) ##[1:20] (code_rd && !entry_avail));
endmodule
`default_nettype wire

/* src/ehm_pkg.sv */
// Notes on behaviour
// - each entry holds motor current at detection, unsigned 16 bits, 0.01 A rms steps
// - power-on cycle count is unsigned 32 bits, zero up to 4294967295
// - each entry holds a 16-bit qualifier whose meaning depends on the error code
// - each entry holds signed 16-bit device and power stage temperatures in degrees Celsius
// - detection time in seconds from operating hours, 32 bits, limited to 536870911
// - each entry holds DC bus voltage at detection, unsigned 16 bits, 0.1 V steps
// - each entry holds signed 32-bit motor velocity in user velocity units
// - each entry holds 16-bit count of power stage enables since control voltage applied
// - each entry holds seconds from last power stage enable until detection, 16 bits
// - writing 1 to pointer reset moves read pointer to the oldest entry at once
// - writing 1 to clear deletes all history entries, effective immediately
// - reading clear returns 0 once deletion finished; master polls until zero
// - each detected error produces a message identified by a unique error code
// - top hex digit of the code gives the error category
// - class 0 keeps movement and state, cleared by fault reset
// - class 1 quick-stops with stage enabled, cleared by fault reset
// - class 2 quick-stops then disables stage at standstill, cleared by fault reset
// - classes 3 and 4 disable stage at once; class 4 cleared only by power cycle
// - reading the error code copies the entry to a holding buffer, then advances pointer
// - history keeps ten most recent entries, oldest first, retained across power-off; count_reg resets, so the history reads empty after reset
// - error code 0 during read-out means no further entries; master stops there
package ehm_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SEC_S = 1;
  localparam int unsigned SEC_CYC = CLK_HZ * SEC_S;
  localparam logic [15:0] A_POWER_ON = 16'h3B04;
  localparam logic [15:0] A_CLEAR = 16'h3B08;
  localparam logic [15:0] A_PTR_RST = 16'h3B0A;
  localparam logic [15:0] A_CODE = 16'h3C02;
  localparam logic [15:0] A_CLASS = 16'h3C04;
  localparam logic [15:0] A_TIME = 16'h3C06;
  localparam logic [15:0] A_QUAL = 16'h3C08;
  localparam logic [15:0] A_EN_CNT = 16'h3C0A;
  localparam logic [15:0] A_EN_TIME = 16'h3C0C;
  localparam logic [15:0] A_DCBUS = 16'h3C0E;
  localparam logic [15:0] A_VEL = 16'h3C10;
  localparam logic [15:0] A_CURR = 16'h3C12;
  localparam logic [15:0] A_TEMP_PS = 16'h3C14;
  localparam logic [15:0] A_TEMP_DEV = 16'h3C16;
  localparam logic [3:0] HIST_DEPTH = 4'hA;
  localparam logic [3:0] CLEAR_CYC = 4'hA;
  localparam logic [31:0] TIME_MAX = 32'h1FFFFFFF;
  localparam logic [31:0] CMD_ON = 32'h00000001;
  localparam logic [31:0] CMD_MAX = 32'h00000001;
  localparam logic [15:0] SAT16 = 16'hFFFF;
  localparam logic [2:0] CLS_0 = 3'h0;
  localparam logic [2:0] CLS_1 = 3'h1;
  localparam logic [2:0] CLS_2 = 3'h2;
  localparam logic [2:0] CLS_3 = 3'h3;
  localparam logic [2:0] CLS_4 = 3'h4;
  typedef enum logic [3:0] {
    CAT_NONE = 4'h0, CAT_GENERAL = 4'h1, CAT_OVERCURRENT = 4'h2, CAT_VOLTAGE = 4'h3,
    CAT_TEMPERATURE = 4'h4, CAT_HARDWARE = 4'h5, CAT_SOFTWARE = 4'h6, CAT_WIRING = 4'h7,
    CAT_FIELDBUS = 4'h8, CAT_MOTION = 4'hA, CAT_COMM = 4'hB
  } ehm_cat_t;
  typedef enum logic [3:0] {
    RX_RUN = 4'h1, RX_QSTOP = 4'h2, RX_BRAKE = 4'h4, RX_OFF = 4'h8
  } ehm_rx_t;
  typedef struct packed {
    logic [15:0] code;
    logic [2:0] cls;
    logic [15:0] qual;
    logic [15:0] current;
    logic [15:0] dc_bus;
    logic signed [31:0] velocity;
    logic signed [15:0] temp_dev;
    logic signed [15:0] temp_ps;
  } ehm_snap_t;
  typedef struct packed {
    ehm_snap_t snap;
    logic [31:0] det_time;
    logic [15:0] en_count;
    logic [15:0] en_time;
  } ehm_entry_t;
endpackage

/* src/ehm_reaction.sv */
`timescale 1ns/10ps
`default_nettype none
module ehm_reaction (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // error events
  input wire logic i_log,
  input wire logic [2:0] i_cls,
  input wire logic i_fault_reset,
  input wire logic i_standstill,
  // reaction
  output logic o_quick_stop,
  output logic o_stage_off,
  output logic o_t_qs,
  output logic o_t_fr,
  output logic o_t_fs,
  output logic o_warning,
  output logic o_fault
);
  ehm_pkg::ehm_rx_t state_reg, state_next;
  logic hard_reg;
  logic t_qs_next, t_fr_next, t_fs_next;

  always_comb begin
    state_next = state_reg;
    t_qs_next = 1'b0;
    t_fr_next = 1'b0;
    t_fs_next = 1'b0;
    if (i_log && (i_cls == ehm_pkg::CLS_3 || i_cls == ehm_pkg::CLS_4) && state_reg != ehm_pkg::RX_OFF) begin
      state_next = ehm_pkg::RX_OFF;
      t_fr_next = 1'b1;
      t_fs_next = 1'b1;
    end else if (i_log && i_cls == ehm_pkg::CLS_2 && (state_reg == ehm_pkg::RX_RUN || state_reg == ehm_pkg::RX_QSTOP)) begin
      state_next = ehm_pkg::RX_BRAKE;
      t_fr_next = 1'b1;
    end else begin
      case (state_reg)
        ehm_pkg::RX_RUN: begin
          if (i_log && i_cls == ehm_pkg::CLS_1) begin
            state_next = ehm_pkg::RX_QSTOP;
            t_qs_next = 1'b1;
          end
        end
        ehm_pkg::RX_QSTOP: begin
          if (i_fault_reset) begin
            state_next = ehm_pkg::RX_RUN;
          end
        end
        ehm_pkg::RX_BRAKE: begin
          if (i_standstill) begin
            state_next = ehm_pkg::RX_OFF;
            t_fs_next = 1'b1;
          end
        end
        ehm_pkg::RX_OFF: begin
          if (i_fault_reset && !hard_reg) begin
            state_next = ehm_pkg::RX_RUN;
          end
        end
        default: state_next = ehm_pkg::RX_RUN;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg <= ehm_pkg::RX_RUN;
      o_quick_stop <= 1'b0;
      o_stage_off <= 1'b0;
      o_t_qs <= 1'b0;
      o_t_fr <= 1'b0;
      o_t_fs <= 1'b0;
      o_fault <= 1'b0;
    end else begin
      state_reg <= state_next;
      o_quick_stop <= state_next == ehm_pkg::RX_QSTOP || state_next == ehm_pkg::RX_BRAKE;
      o_stage_off <= state_next == ehm_pkg::RX_OFF;
      o_t_qs <= t_qs_next;
      o_t_fr <= t_fr_next;
      o_t_fs <= t_fs_next;
      o_fault <= state_next != ehm_pkg::RX_RUN;
    end
  end

  // class 4 latch survives fault reset, only reset (power cycle) clears it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      hard_reg <= 1'b0;
    end else if (i_log && i_cls == ehm_pkg::CLS_4) begin
      hard_reg <= 1'b1;
    end
  end

  // class 0 only flags, set wins over fault reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_warning <= 1'b0;
    end else if (i_log && i_cls == ehm_pkg::CLS_0) begin
      o_warning <= 1'b1;
    end else if (i_fault_reset) begin
      o_warning <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_cls0_no_stop;
    (state_reg == ehm_pkg::RX_RUN && i_log && i_cls == ehm_pkg::CLS_0) |=> !o_quick_stop && !o_stage_off && o_warning;
  endproperty
  a_cls0_no_stop: assert property (p_cls0_no_stop) else $error("class 0 changed the motion state");
  property p_cls1_qstop;
    (state_reg == ehm_pkg::RX_RUN && i_log && i_cls == ehm_pkg::CLS_1) |=> o_quick_stop && !o_stage_off && o_t_qs;
  endproperty
  a_cls1_qstop: assert property (p_cls1_qstop) else $error("class 1 did not quick stop with stage on");
  property p_cls2_off_at_standstill;
    (state_reg == ehm_pkg::RX_BRAKE && i_standstill && !i_log) |=> o_stage_off && o_t_fs && !o_quick_stop;
  endproperty
  a_cls2_off_at_standstill: assert property (p_cls2_off_at_standstill) else $error("class 2 stage not off");
  property p_cls34_off;
    (i_log && (i_cls == ehm_pkg::CLS_3 || i_cls == ehm_pkg::CLS_4)) |=> o_stage_off && !o_quick_stop;
  endproperty
  a_cls34_off: assert property (p_cls34_off) else $error("class 3 or 4 did not disable stage");
  property p_cls4_sticky;
    (hard_reg && o_stage_off && i_fault_reset) |=> o_stage_off;
  endproperty
  a_cls4_sticky: assert property (p_cls4_sticky) else $error("fault reset cleared class 4");
  c_brake_to_off: cover property (state_reg == ehm_pkg::RX_BRAKE ##1 state_reg == ehm_pkg::RX_OFF);
endmodule
`default_nettype wire

/* src/ehm_store.sv */
`timescale 1ns/10ps
`default_nettype none
module ehm_store (
  // clock
  input wire logic i_clk,
  // write port
  input wire logic i_wr,
  input wire logic [3:0] i_wr_idx,
  input wire ehm_pkg::ehm_entry_t i_wr_data,
  // read port
  input wire logic [3:0] i_rd_idx,
  output ehm_pkg::ehm_entry_t o_rd_data
);
  // no reset: contents belong to the retained domain
  ehm_pkg::ehm_entry_t mem [ehm_pkg::HIST_DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_wr) begin
      mem[i_wr_idx] <= i_wr_data;
    end
  end

  assign o_rd_data = mem[i_rd_idx];
endmodule
`default_nettype wire
